// ### tb/lpm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
    input wire logic mclk_i,        // Clock
    input wire logic rst_b_i,       // Async reset, low
    input wire logic go_i,          // Bench asks for entry
    input wire logic cpu_clk_en_i,  // Core clock running
    input wire logic core_rst_b_i,  // Core reset, low
    output logic core_lp_req_o      // One-cycle entry request
);
    // A stopped or held core cannot ask; one pulse per ask
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_lp_req_o <= 1'h0;
        end else begin
            core_lp_req_o <= go_i & cpu_clk_en_i & core_rst_b_i
                & ~core_lp_req_o;
        end
    end
endmodule : lpm_core_model
`default_nettype wire

// ### tb/lpm_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lpm_ctrl_tb;
    logic mclk_i;
    logic rst_b = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, go = 1'h0;
    logic irq = 1'h0, wkp = 1'h0, rpin_b = 1'h1, req, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rd, wb_dat;
    logic [3:0] sel = 4'hF;
    logic [18:0] ev = 19'h0;
    logic [1:0] rmode;
    logic ren, cpuen, d18, pll, irc_en, xosc_en, lsi, rtcen, lost, crst_b, wdr;
    int mismatches = 0, n_compared = 0, i, n;

    lpm_ctrl i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(wb_dat), .wb_ack_o(ack),
        .core_lp_req_i(req), .periph_irq_i(irq), .rtc_alarm_i(ev[17]),
        .ext_lines_i(ev[15:0]), .supply_detector_i(ev[16]),
        .usb_wake_i(ev[18]), .wakeup_pin_i(wkp), .ext_reset_pin_b_i(rpin_b),
        .reg_mode_o(rmode), .reg_en_o(ren), .cpu_clk_en_o(cpuen),
        .dom18_clk_en_o(d18), .pll_en_o(pll), .int_hs_rc_en_o(irc_en),
        .ext_hs_osc_en_o(xosc_en), .lsi_en_o(lsi), .rtc_clk_en_o(rtcen),
        .core_state_lost_o(lost), .core_rst_b_o(crst_b), .wdog_rst_o(wdr));
    lpm_core_model i_core (.mclk_i(mclk_i), .rst_b_i(rst_b), .go_i(go),
        .cpu_clk_en_i(cpuen), .core_rst_b_i(crst_b), .core_lp_req_o(req));

    initial begin
        mclk_i = 1'h0;
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge mclk_i);
        while (ack !== 1'h1 && k < 20) begin
            @(posedge mclk_i);
            k++;
        end
        if (k == 20) `CHK(ack, 1'h1)
        rd = wb_dat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask : wb

    task automatic enter;
        @(posedge mclk_i);
        go <= 1'h1;
        @(posedge mclk_i);
        go <= 1'h0;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : enter

    task automatic wait_run(input int lim);
        int k;
        k = 0;
        while (!(cpuen === 1'h1 && crst_b === 1'h1) && k < lim) begin
            @(posedge mclk_i);
            k++;
        end
    endtask : wait_run

    // Waits for core reset, frees wake sources, measures reset length
    task automatic wait_restart(input bit cnt);
        int k;
        k = 0;
        while (crst_b !== 1'h0 && k < 6000) begin
            @(posedge mclk_i);
            k++;
        end
        `CHK({crst_b, lost}, 2'h1)
        ev <= 19'h0;
        wkp <= 1'h0;
        rpin_b <= 1'h1;
        n = 0;
        do begin
            n++;
            @(posedge mclk_i);
        end while (crst_b === 1'h0 && n < 100);
        if (cnt) `CHK(n, lpm_pkg::RESTART_CYC)
        wait_run(100);
        @(negedge mclk_i);
        `CHK({cpuen, ren, rmode}, {2'h3, lpm_pkg::REG_MAIN})
    endtask : wait_restart

    initial begin
        #(40 * 40000);
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        rst_b <= 1'h1;
        @(negedge mclk_i);
        `CHK({rmode, ren, cpuen}, 4'h3)
        `CHK({d18, pll, irc_en, xosc_en}, 4'hF)
        `CHK({lsi, rtcen, crst_b, lost, wdr}, 5'h1C)
        wb(1'h0, lpm_pkg::ADDR_CTRL, 32'h0);
        `CHK(rd, lpm_pkg::CTRL_RST)
        wb(1'h0, lpm_pkg::ADDR_EVMASK, 32'h0);
        `CHK(rd, lpm_pkg::EVMASK_RST)
        wb(1'h0, lpm_pkg::ADDR_WDCFG, 32'h0);
        `CHK(rd, lpm_pkg::WDCFG_RST)
        wb(1'h0, 8'h20, 32'h0);
        `CHK(rd, 32'h0)
        // Sleep: only the core clock stops
        enter();
        `CHK({cpuen, d18, pll, ren, rmode}, {4'h7, lpm_pkg::REG_MAIN})
        @(posedge mclk_i);
        irq <= 1'h1;
        @(posedge mclk_i);
        irq <= 1'h0;
        @(negedge mclk_i);
        `CHK(cpuen, 1'h1)
        // Stop, woken by each event source in turn
        for (i = 0; i < 19; i++) begin
            wb(1'h1, lpm_pkg::ADDR_CTRL, {29'h0, i[0], 2'h1});
            enter();
            `CHK({d18, pll, irc_en, xosc_en, ren, cpuen}, 6'h02)
            `CHK(rmode, i[0] ? lpm_pkg::REG_LP : lpm_pkg::REG_MAIN)
            `CHK({lsi, rtcen}, 2'h3)
            @(posedge mclk_i);
            ev <= 19'h1 << i;
            wait_run(10);
            ev <= 19'h0;
            @(negedge mclk_i);
            `CHK({cpuen, d18, pll, rmode}, {3'h7, lpm_pkg::REG_MAIN})
        end
        // Masked line keeps Stop, an enabled one wakes
        wb(1'h1, lpm_pkg::ADDR_EVMASK, 32'h0007_FFFE);
        wb(1'h1, lpm_pkg::ADDR_CTRL, 32'h0000_0001);
        enter();
        @(posedge mclk_i);
        ev <= 19'h1;
        repeat (6) @(posedge mclk_i);
        `CHK({cpuen, d18}, 2'h0)
        ev <= 19'h3;
        wait_run(10);
        ev <= 19'h0;
        @(negedge mclk_i);
        `CHK(cpuen, 1'h1)
        // Standby left by alarm, wakeup pin edge, reset pin
        for (i = 0; i < 3; i++) begin
            wb(1'h1, lpm_pkg::ADDR_CTRL, 32'h0000_000B);
            enter();
            `CHK({ren, pll, irc_en, xosc_en, d18}, 5'h0)
            `CHK(rmode, lpm_pkg::REG_OFF)
            `CHK({lost, lsi, rtcen}, 3'h7)
            @(posedge mclk_i);
            if (i == 0) ev[17] <= 1'h1;
            if (i == 1) wkp <= 1'h1;
            if (i == 2) rpin_b <= 1'h0;
            wait_restart(i != 2);
            wb(1'h0, lpm_pkg::ADDR_CTRL, 32'h0);
            `CHK(rd, 32'h0)
            wb(1'h0, lpm_pkg::ADDR_STATUS, 32'h0);
            `CHK(rd[5:0], (i == 0) ? 6'h20 : 6'h30)
        end
        wb(1'h1, lpm_pkg::ADDR_STATUS, 32'h0000_0030);
        wb(1'h0, lpm_pkg::ADDR_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        // Watchdog runs through Standby and ends it
        wb(1'h1, lpm_pkg::ADDR_WDCFG, 32'h0002_0001);
        wb(1'h1, lpm_pkg::ADDR_WDCFG, 32'h0FFF_0000);
        wb(1'h0, lpm_pkg::ADDR_WDCFG, 32'h0);
        `CHK(rd, 32'h0002_0001)
        // Kick loads the short reload value
        wb(1'h1, lpm_pkg::ADDR_WDKICK, 32'h0);
        wb(1'h1, lpm_pkg::ADDR_CTRL, 32'h0000_0003);
        enter();
        `CHK({ren, lsi}, 2'h1)
        n = 0;
        while (wdr !== 1'h1 && n < 5000) begin
            @(posedge mclk_i);
            n++;
        end
        `CHK(wdr, 1'h1)
        @(posedge mclk_i);
        `CHK(wdr, 1'h0)
        wait_restart(1'h1);
        finish_test();
    end
endmodule : lpm_ctrl_tb
`default_nettype wire

// ### verilog/lpm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl #(
    parameter int NUM_LINES = lpm_pkg::NUM_LINES
) (
    input wire logic mclk_i,                    // 25 MHz clock
    input wire logic rst_b_i,                   // Async reset, low
    input wire logic wb_cyc_i,                  // Wishbone cycle
    input wire logic wb_stb_i,                  // Wishbone strobe
    input wire logic wb_we_i,                   // Wishbone write
    input wire logic [7:0] wb_adr_i,            // Byte address
    input wire logic [31:0] wb_dat_i,           // Write data
    input wire logic [3:0] wb_sel_i,            // Byte enables
    output logic [31:0] wb_dat_o,               // Read data
    output logic wb_ack_o,                      // Acknowledge
    input wire logic core_lp_req_i,             // Core mode entry pulse
    input wire logic periph_irq_i,              // Any peripheral irq
    input wire logic rtc_alarm_i,               // RTC alarm, same clock
    input wire logic [NUM_LINES-1:0] ext_lines_i, // External event pins
    input wire logic supply_detector_i,         // Supply detector out
    input wire logic usb_wake_i,                // USB wakeup
    input wire logic wakeup_pin_i,              // Wakeup pin
    input wire logic ext_reset_pin_b_i,         // Reset pin, low
    output logic [1:0] reg_mode_o,              // Regulator mode
    output logic reg_en_o,                      // Regulator enable
    output logic cpu_clk_en_o,                  // CPU clock gate
    output logic dom18_clk_en_o,                // 1.8 V domain clocks
    output logic pll_en_o,                      // PLL enable
    output logic int_hs_rc_en_o,                // Internal fast RC
    output logic ext_hs_osc_en_o,               // External fast osc
    output logic lsi_en_o,                      // 40 kHz RC enable
    output logic rtc_clk_en_o,                  // RTC clock enable
    output logic core_state_lost_o,             // Core contents invalid
    output logic core_rst_b_o,                  // Core reset, low
    output logic wdog_rst_o                     // Watchdog reset pulse
);
    localparam int EVW = NUM_LINES + 3;
    localparam int LSI_W = $clog2(lpm_pkg::LSI_DIV);
    localparam int RST_W = $clog2(lpm_pkg::RESTART_CYC + 1);
    localparam logic [31:0] EVMASK_W = 32'h0007_FFFF;

    lpm_pkg::lpm_state_t state_q, state_d;
    logic [31:0] ctrl_q, evmask_q, wdcfg_q, rdata;
    logic wuf_q, sbf_q, ack_q, wd_run_q, wd_fire_q;
    logic [EVW-1:0] ev_s1_q, ev_s2_q;
    logic [1:0] pin_s1_q, pin_s2_q;
    logic wkp_prev_q;
    logic [LSI_W-1:0] lsi_cnt_q;
    logic [lpm_pkg::WD_PRE_W-1:0] pre_cnt_q;
    logic [lpm_pkg::WD_CNT_W-1:0] wd_cnt_q;
    logic [RST_W-1:0] rst_cnt_q;

    // Bus decode
    wire acc = wb_cyc_i & wb_stb_i;
    wire wr_commit = acc & wb_we_i & ack_q;
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire wr_ctrl = wr_commit & (wb_adr_i == lpm_pkg::ADDR_CTRL);
    wire wr_evm = wr_commit & (wb_adr_i == lpm_pkg::ADDR_EVMASK);
    wire wr_stat = wr_commit & (wb_adr_i == lpm_pkg::ADDR_STATUS);
    wire wr_wdcfg = wr_commit & (wb_adr_i == lpm_pkg::ADDR_WDCFG);
    wire wr_kick = wr_commit & (wb_adr_i == lpm_pkg::ADDR_WDKICK);
    wire [31:0] wdata_m = wb_dat_i & bmask;

    // Synchronised pins
    wire [EVW-1:0] ev_raw = {usb_wake_i, rtc_alarm_i, supply_detector_i,
                             ext_lines_i};
    wire wkp_s = pin_s2_q[0];
    wire rst_pin_low = ~pin_s2_q[1];
    wire wkp_rise = wkp_s & ~wkp_prev_q;
    wire [EVW-1:0] ev_hit = ev_s2_q & evmask_q[EVW-1:0];
    wire any_event = |ev_hit;

    // Watchdog tick chain
    wire lsi_tick = (lsi_cnt_q == LSI_W'(lpm_pkg::LSI_DIV - 1));
    wire [lpm_pkg::WD_PRE_W-1:0] pre_div =
        wdcfg_q[lpm_pkg::WDCFG_PRE_LSB +: lpm_pkg::WD_PRE_W];
    wire [lpm_pkg::WD_CNT_W-1:0] wd_reload =
        wdcfg_q[lpm_pkg::WDCFG_RLD_LSB +: lpm_pkg::WD_CNT_W];
    wire pre_tick = lsi_tick & (pre_cnt_q == pre_div);
    wire wd_expire = wd_run_q & pre_tick & (wd_cnt_q == '0);

    wire in_standby = (state_q == lpm_pkg::LPM_STANDBY);
    wire in_stop = (state_q == lpm_pkg::LPM_STOP);
    wire hard_wake = rst_pin_low | wd_fire_q;
    wire sb_wake = hard_wake | rtc_alarm_i
                   | (ctrl_q[lpm_pkg::CTRL_WKEN] & wkp_rise);
    wire rst_done = (rst_cnt_q == RST_W'(lpm_pkg::RESTART_CYC - 1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            lpm_pkg::LPM_RUN: begin
                if (hard_wake) begin
                    state_d = lpm_pkg::LPM_RESTART;
                end else if (core_lp_req_i) begin
                    if (!ctrl_q[lpm_pkg::CTRL_DEEP]) begin
                        state_d = lpm_pkg::LPM_SLEEP;
                    end else if (ctrl_q[lpm_pkg::CTRL_STANDBY]) begin
                        state_d = lpm_pkg::LPM_STANDBY;
                    end else begin
                        state_d = lpm_pkg::LPM_STOP;
                    end
                end
            end
            lpm_pkg::LPM_SLEEP: begin
                if (hard_wake) begin
                    state_d = lpm_pkg::LPM_RESTART;
                end else if (periph_irq_i | any_event) begin
                    state_d = lpm_pkg::LPM_RUN;
                end
            end
            lpm_pkg::LPM_STOP: begin
                if (hard_wake) begin
                    state_d = lpm_pkg::LPM_RESTART;
                end else if (any_event) begin
                    state_d = lpm_pkg::LPM_RUN;
                end
            end
            lpm_pkg::LPM_STANDBY: begin
                if (sb_wake) begin
                    state_d = lpm_pkg::LPM_RESTART;
                end
            end
            lpm_pkg::LPM_RESTART: begin
                if (rst_done) begin
                    state_d = lpm_pkg::LPM_RUN;
                end
            end
            default: begin
                state_d = lpm_pkg::LPM_RESTART;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= lpm_pkg::LPM_RUN;
            rst_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            rst_cnt_q <= (state_q == lpm_pkg::LPM_RESTART) ?
                         rst_cnt_q + RST_W'(1) : '0;
        end
    end

    // Power and clock outputs
    assign reg_en_o = ~in_standby;
    assign reg_mode_o = in_standby ? lpm_pkg::REG_OFF :
        (in_stop && ctrl_q[lpm_pkg::CTRL_LP_REG]) ? lpm_pkg::REG_LP :
        lpm_pkg::REG_MAIN;
    assign cpu_clk_en_o = (state_q == lpm_pkg::LPM_RUN);
    assign dom18_clk_en_o = ~in_stop & ~in_standby;
    assign pll_en_o = ~in_stop & ~in_standby;
    assign int_hs_rc_en_o = ~in_stop & ~in_standby;
    assign ext_hs_osc_en_o = ~in_stop & ~in_standby;
    assign lsi_en_o = 1'b1;
    assign rtc_clk_en_o = 1'b1;
    assign core_state_lost_o = in_standby
        | (state_q == lpm_pkg::LPM_RESTART);
    assign core_rst_b_o = (state_q != lpm_pkg::LPM_RESTART);
    assign wdog_rst_o = wd_fire_q;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            pin_s1_q <= 2'h2;
            pin_s2_q <= 2'h2;
            wkp_prev_q <= 1'b0;
        end else begin
            ev_s1_q <= ev_raw;
            ev_s2_q <= ev_s1_q;
            pin_s1_q <= {ext_reset_pin_b_i, wakeup_pin_i};
            pin_s2_q <= pin_s1_q;
            wkp_prev_q <= wkp_s;
        end
    end

    // Watchdog on the 40 kHz tick, never gated by mode
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lsi_cnt_q <= '0;
            pre_cnt_q <= '0;
            wd_cnt_q <= '1;
            wd_run_q <= 1'b0;
            wd_fire_q <= 1'b0;
        end else begin
            lsi_cnt_q <= lsi_tick ? '0 : lsi_cnt_q + LSI_W'(1);
            if (lsi_tick) begin
                pre_cnt_q <= pre_tick ? '0 : pre_cnt_q + 8'h01;
            end
            if (wr_wdcfg && wb_sel_i[0]
                && wb_dat_i[lpm_pkg::WDCFG_START]) begin
                wd_run_q <= 1'b1;
            end
            if (wr_kick || wd_expire) begin
                wd_cnt_q <= wd_reload;
            end else if (wd_run_q && pre_tick) begin
                wd_cnt_q <= wd_cnt_q - 12'h001;
            end
            wd_fire_q <= wd_expire;
        end
    end

    // Registers; standby exit clears the lost control state
    wire sb_exit = in_standby & sb_wake;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= lpm_pkg::CTRL_RST;
            evmask_q <= lpm_pkg::EVMASK_RST;
            wdcfg_q <= lpm_pkg::WDCFG_RST;
            wuf_q <= 1'b0;
            sbf_q <= 1'b0;
        end else begin
            if (sb_exit) begin
                ctrl_q <= lpm_pkg::CTRL_RST;
                evmask_q <= lpm_pkg::EVMASK_RST;
            end else begin
                if (wr_ctrl) begin
                    ctrl_q <= (ctrl_q & ~bmask) | (wdata_m & 32'h0000_000F);
                end
                if (wr_evm) begin
                    evmask_q <= (evmask_q & ~bmask) | (wdata_m & EVMASK_W);
                end
            end
            if (wr_wdcfg && !wd_run_q) begin
                wdcfg_q <= (wdcfg_q & ~bmask) | (wdata_m & 32'h0FFF_FF00);
            end
            // Set wins over a write-one clear
            if (sb_exit && wkp_rise) begin
                wuf_q <= 1'b1;
            end else if (wr_stat && wdata_m[lpm_pkg::STAT_WUF]) begin
                wuf_q <= 1'b0;
            end
            if (sb_exit) begin
                sbf_q <= 1'b1;
            end else if (wr_stat && wdata_m[lpm_pkg::STAT_SBF]) begin
                sbf_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (wb_adr_i)
            lpm_pkg::ADDR_CTRL: rdata = ctrl_q;
            lpm_pkg::ADDR_EVMASK: rdata = evmask_q;
            lpm_pkg::ADDR_STATUS: rdata = {26'h0, sbf_q, wuf_q, 1'b0, state_q};
            lpm_pkg::ADDR_WDCFG: rdata = {wdcfg_q[31:1], wd_run_q};
            lpm_pkg::ADDR_WDCNT: rdata = {20'h0, wd_cnt_q};
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= acc & ~ack_q;
            wb_dat_o <= (acc & ~ack_q & ~wb_we_i) ? rdata : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_q;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_lp_entry;
        (state_q == lpm_pkg::LPM_RUN) && !hard_wake && core_lp_req_i;
    endsequence
    sequence s_restart_hold;
        (!core_rst_b_o)[*2];
    endsequence

    property p_run_main;
        (state_q == lpm_pkg::LPM_RUN) |-> reg_mode_o == lpm_pkg::REG_MAIN;
    endproperty
    a_run_main: assert property (p_run_main)
        else $error("Regulator not in main mode during run");
    property p_standby_off;
        s_lp_entry ##0 ctrl_q[lpm_pkg::CTRL_DEEP] &&
        ctrl_q[lpm_pkg::CTRL_STANDBY] |=> !reg_en_o
        && reg_mode_o == lpm_pkg::REG_OFF && core_state_lost_o;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("Standby entry did not power down regulator");
    property p_reg_on;
        (state_q == lpm_pkg::LPM_RESTART) |-> reg_en_o
        && reg_mode_o == lpm_pkg::REG_MAIN;
    endproperty
    a_reg_on: assert property (p_reg_on)
        else $error("Regulator off during core restart");
    property p_sleep;
        s_lp_entry ##0 !ctrl_q[lpm_pkg::CTRL_DEEP] |=> !cpu_clk_en_o
        && dom18_clk_en_o && pll_en_o;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Sleep gated more than the CPU clock");
    property p_sleep_wake;
        (state_q == lpm_pkg::LPM_SLEEP) && periph_irq_i && !hard_wake
        |=> cpu_clk_en_o;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("Interrupt did not wake from sleep");
    property p_stop_clocks;
        in_stop |-> !dom18_clk_en_o && !pll_en_o && !int_hs_rc_en_o
        && !ext_hs_osc_en_o && reg_en_o;
    endproperty
    a_stop_clocks: assert property (p_stop_clocks)
        else $error("Clock left running in stop");
    property p_stop_lp_reg;
        in_stop |-> reg_mode_o == (ctrl_q[lpm_pkg::CTRL_LP_REG] ?
        lpm_pkg::REG_LP : lpm_pkg::REG_MAIN);
    endproperty
    a_stop_lp_reg: assert property (p_stop_lp_reg)
        else $error("Stop regulator mode not as selected");
    property p_stop_wake;
        in_stop && !hard_wake && $rose(ev_s2_q[0]) && evmask_q[0]
        |=> state_q == lpm_pkg::LPM_RUN;
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("Event line did not wake from stop");
    property p_standby_osc;
        in_standby |-> !pll_en_o && !int_hs_rc_en_o && !ext_hs_osc_en_o;
    endproperty
    a_standby_osc: assert property (p_standby_osc)
        else $error("Oscillator left on in standby");
    property p_sb_exit;
        in_standby && rtc_alarm_i |=> s_restart_hold;
    endproperty
    a_sb_exit: assert property (p_sb_exit)
        else $error("RTC alarm did not restart core from standby");
    property p_always_on;
        lsi_en_o && rtc_clk_en_o;
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("Always-on clock stopped");
    property p_wd_fire;
        wd_expire |=> wdog_rst_o && wd_cnt_q == wd_reload;
    endproperty
    a_wd_fire: assert property (p_wd_fire)
        else $error("Watchdog expiry did not reset");
    property p_wd_dec;
        wd_run_q && pre_tick && !wr_kick && wd_cnt_q != '0
        |=> wd_cnt_q == $past(wd_cnt_q) - 12'h001;
    endproperty
    a_wd_dec: assert property (p_wd_dec)
        else $error("Watchdog counter did not step down");
endmodule : lpm_ctrl
`default_nettype wire

// ### verilog/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int LSI_HZ = 40_000;
    localparam int LSI_DIV = CLK_HZ / LSI_HZ;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESTART_NS = 640;
    localparam int RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_LINES = 16;
    localparam int WD_CNT_W = 12;
    localparam int WD_PRE_W = 8;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_EVMASK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_WDCFG = 8'h0C;
    localparam logic [7:0] ADDR_WDKICK = 8'h10;
    localparam logic [7:0] ADDR_WDCNT = 8'h14;

    localparam int CTRL_DEEP = 0;
    localparam int CTRL_STANDBY = 1;
    localparam int CTRL_LP_REG = 2;
    localparam int CTRL_WKEN = 3;
    localparam int STAT_WUF = 4;
    localparam int STAT_SBF = 5;
    localparam int WDCFG_START = 0;
    localparam int WDCFG_PRE_LSB = 8;
    localparam int WDCFG_RLD_LSB = 16;
    localparam int EV_SVD = 16;
    localparam int EV_RTC = 17;
    localparam int EV_USB = 18;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] EVMASK_RST = 32'h0007_FFFF;
    localparam logic [31:0] WDCFG_RST = 32'h0FFF_0000;

    localparam logic [1:0] REG_MAIN = 2'h0;
    localparam logic [1:0] REG_LP = 2'h1;
    localparam logic [1:0] REG_OFF = 2'h2;

    typedef enum logic [2:0] {
        LPM_RUN,
        LPM_SLEEP,
        LPM_STOP,
        LPM_STANDBY,
        LPM_RESTART
    } lpm_state_t;
endpackage : lpm_pkg
`default_nettype wire
